/* rtl/rx_clock_cfg.svh */
// constants for the receive clock, reclocker status and reset block
`ifndef RX_CLOCK_CFG_SVH
`define RX_CLOCK_CFG_SVH

`define ADDR_W            4
`define DATA_W            32
`define CHAR_W            10
`define CNT_W             8

`define OFF_CTRL          4'h0
`define OFF_STATUS        4'h4
`define OFF_IRQ_STAT      4'h8
`define OFF_IRQ_MASK      4'hC

`define CTRL_RATE_BIT     0
`define CTRL_SEL_LO       1
`define CTRL_SEL_HI       2
`define CTRL_EN1_BIT      3
`define CTRL_EN2_BIT      4
`define CTRL_W            5
`define CTRL_RESET        5'h18

`define SEL_SELF_TEST     2'h2

`define EVT_POWERDOWN     0
`define EVT_LOCK          1
`define EVT_W             2

`define CNT_MAX           8'hFF

`endif

/* rtl/rx_clock_pkg.sv */
// types for the receive clock, reclocker status and reset block
`include "rx_clock_cfg.svh"
package rx_clock_pkg;

  typedef struct packed {
    logic       enable_two;
    logic       enable_one;
    logic [1:0] self_test_select;
    logic       rate_select;
  } ctrl_s;

  typedef struct packed {
    logic [`ADDR_W-1:0] addr;
    logic [`DATA_W-1:0] wdata;
    logic               wr;
    logic               rd;
  } bus_req_s;

  typedef struct packed {
    logic [`CHAR_W-1:0] data;
    logic               strobe;
    logic               valid;
  } char_in_s;

  typedef struct packed {
    logic       status;
    logic [1:0] code;
  } self_test_s;

  typedef enum logic [0:0] {
    PH_LOW  = 1'b0,
    PH_HIGH = 1'b1
  } phase_e;

endpackage : rx_clock_pkg

/* rtl/rx_clock_reclock_status_reset.sv */
// receive clock outputs, reclocker status, self-test gating and reset
//
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "rx_clock_cfg.svh"

module rx_clock_reclock_status_reset (
  input  wire logic                   clock,
  input  wire logic                   rst,
  input  wire logic [`ADDR_W-1:0]     addr,
  input  wire logic [`DATA_W-1:0]     wdata,
  input  wire logic                   wr,
  input  wire logic                   rd,
  output logic      [`DATA_W-1:0]     rdata,
  input  wire logic                   training_clock,
  input  wire logic                   char_valid,
  input  wire logic                   char_strobe,
  input  wire logic [`CHAR_W-1:0]     char_data,
  input  wire logic                   self_test_status,
  input  wire logic [1:0]             self_test_code,
  output logic                        recovered_interface_clock_p,
  output logic                        recovered_interface_clock_n,
  output logic                        reclocker_clock_out,
  output logic      [`CHAR_W-1:0]     rx_parallel_data,
  output logic                        self_test_status_out,
  output logic                        reclock_powerdown_flag,
  output logic                        irq
);

  rx_clock_pkg::bus_req_s   req;
  rx_clock_pkg::char_in_s   chr;
  rx_clock_pkg::self_test_s st;

  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
  assign chr = '{data: char_data, strobe: char_strobe, valid: char_valid};
  assign st  = '{status: self_test_status, code: self_test_code};

  // training clock synchroniser and edge finder
  logic trg_meta_reg, trg_sync_reg, trg_prev_reg;
  logic trg_meta_next, trg_sync_next, trg_prev_next;
  logic trg_rise;

  always_comb begin
    trg_meta_next = training_clock;
    trg_sync_next = trg_meta_reg;
    trg_prev_next = trg_sync_reg;
  end

  assign trg_rise = trg_sync_reg & ~trg_prev_reg;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      trg_meta_reg <= 1'b0;
      trg_sync_reg <= 1'b0;
      trg_prev_reg <= 1'b0;
    end else begin
      trg_meta_reg <= trg_meta_next;
      trg_sync_reg <= trg_sync_next;
      trg_prev_reg <= trg_prev_next;
    end
  end

  // configuration and interrupt registers
  rx_clock_pkg::ctrl_s ctrl_reg, ctrl_next;
  logic [`EVT_W-1:0]   irq_stat_reg, irq_stat_next;
  logic [`EVT_W-1:0]   irq_mask_reg, irq_mask_next;
  logic [`DATA_W-1:0]  rdata_next;
  logic                irq_next;
  logic [`EVT_W-1:0]   events;
  logic                powerdown_reg, powerdown_next;
  logic                locked_reg, locked_next;

  // software writes to control and mask
  always_comb begin
    ctrl_next     = ctrl_reg;
    irq_mask_next = irq_mask_reg;
    if (req.wr) begin
      unique case (req.addr)
        `OFF_CTRL:     ctrl_next = rx_clock_pkg::ctrl_s'(req.wdata[`CTRL_W-1:0]);
        `OFF_IRQ_MASK: irq_mask_next = req.wdata[`EVT_W-1:0];
        default:       ;
      endcase
    end
  end

  // all configuration starts from constants
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_reg     <= rx_clock_pkg::ctrl_s'(`CTRL_RESET);
      irq_mask_reg <= '0;
    end else begin
      ctrl_reg     <= ctrl_next;
      irq_mask_reg <= irq_mask_next;
    end
  end

  // sticky event bits, write one to clear; a new event wins over the clear
  always_comb begin
    irq_stat_next = irq_stat_reg;
    if (req.wr && (req.addr == `OFF_IRQ_STAT)) begin
      irq_stat_next = irq_stat_reg & ~req.wdata[`EVT_W-1:0];
    end
    irq_stat_next = irq_stat_next | events;
    irq_next      = |(irq_stat_next & irq_mask_next);
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_stat_reg <= '0;
      irq          <= 1'b0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      irq          <= irq_next;
    end
  end

  // read data stands one cycle after the read strobe, zero otherwise
  always_comb begin
    rdata_next = '0;
    if (req.rd) begin
      unique case (req.addr)
        `OFF_CTRL:     rdata_next = {{(`DATA_W-`CTRL_W){1'b0}}, ctrl_reg};
        `OFF_STATUS:   rdata_next = {{(`DATA_W-2){1'b0}}, locked_reg, powerdown_reg};
        `OFF_IRQ_STAT: rdata_next = {{(`DATA_W-`EVT_W){1'b0}}, irq_stat_reg};
        `OFF_IRQ_MASK: rdata_next = {{(`DATA_W-`EVT_W){1'b0}}, irq_mask_reg};
        default:       rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata <= '0;
    end else begin
      rdata <= rdata_next;
    end
  end

  // powered-down status and lock source tracking
  always_comb begin
    powerdown_next = ~(ctrl_reg.enable_one | ctrl_reg.enable_two);
    locked_next    = chr.valid;
    events         = '0;
    events[`EVT_POWERDOWN] = powerdown_next ^ powerdown_reg;
    events[`EVT_LOCK]      = locked_next ^ locked_reg;
  end

  // reset control keeps both enables on, so the flag starts low and stays low until software clears both enables
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      powerdown_reg <= 1'b0;
      locked_reg    <= 1'b0;
    end else begin
      powerdown_reg <= powerdown_next;
      locked_reg    <= locked_next;
    end
  end

  assign reclock_powerdown_flag = powerdown_reg;

  // character event source: data when valid, training clock otherwise
  logic char_evt;

  assign char_evt = chr.valid ? chr.strobe : trg_rise;

  // character period measurement for the mid-character edge
  logic [`CNT_W-1:0]  cnt_reg, cnt_next;
  logic [`CNT_W-1:0]  half_reg, half_next;
  rx_clock_pkg::phase_e phase_reg, phase_next;
  logic               mid_evt;

  assign mid_evt = (phase_reg == rx_clock_pkg::PH_HIGH) && (cnt_reg == half_reg);

  always_comb begin
    cnt_next   = cnt_reg;
    half_next  = half_reg;
    phase_next = phase_reg;
    if (char_evt) begin
      half_next  = cnt_reg >> 1;
      cnt_next   = '0;
      phase_next = rx_clock_pkg::PH_HIGH;
    end else begin
      if (cnt_reg != `CNT_MAX) begin
        cnt_next = cnt_reg + 1'b1;
      end
      if (mid_evt) begin
        phase_next = rx_clock_pkg::PH_LOW;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_reg   <= '0;
      half_reg  <= '0;
      phase_reg <= rx_clock_pkg::PH_LOW;
    end else begin
      cnt_reg   <= cnt_next;
      half_reg  <= half_next;
      phase_reg <= phase_next;
    end
  end

  // reclocker clock: character rate square wave from internal events
  logic               reclk_next;

  always_comb begin
    reclk_next = reclocker_clock_out;
    if (char_evt) begin
      reclk_next = 1'b1;
    end else if (mid_evt) begin
      reclk_next = 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reclocker_clock_out <= 1'b0;
    end else begin
      reclocker_clock_out <= reclk_next;
    end
  end

  // interface clock pair, complement always the inverse of the true phase
  logic               clk_p_next, clk_n_next;

  always_comb begin
    clk_p_next = recovered_interface_clock_p;
    if (ctrl_reg.rate_select) begin
      // half rate: toggle each character, data on both edges
      if (char_evt) begin
        clk_p_next = ~recovered_interface_clock_p;
      end
    end else begin
      // full rate: same as reclocker clock, data on rising edge
      clk_p_next = reclk_next;
    end
    clk_n_next = ~clk_p_next;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      recovered_interface_clock_p <= 1'b0;
      recovered_interface_clock_n <= 1'b1;
    end else begin
      recovered_interface_clock_p <= clk_p_next;
      recovered_interface_clock_n <= clk_n_next;
    end
  end

  // parallel data taken at each character event
  logic [`CHAR_W-1:0] data_next;

  always_comb begin
    data_next = rx_parallel_data;
    if (char_evt) begin
      data_next = chr.data;
      if (ctrl_reg.self_test_select == `SEL_SELF_TEST) begin
        data_next[1:0] = st.code;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rx_parallel_data <= '0;
    end else begin
      rx_parallel_data <= data_next;
    end
  end

  // status pin held low outside self-test, host ignores it
  logic               st_out_next;

  always_comb begin
    st_out_next = 1'b0;
    if (ctrl_reg.self_test_select == `SEL_SELF_TEST) begin
      st_out_next = st.status;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      self_test_status_out <= 1'b0;
    end else begin
      self_test_status_out <= st_out_next;
    end
  end

endmodule : rx_clock_reclock_status_reset

`default_nettype wire

/* verification/rx_clock_props.sv */
// checker for clock outputs, flag and self-test gating
`timescale 1ns/100ps
`default_nettype none
module rx_clock_props (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic [3:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        char_valid,
  input wire logic        char_strobe,
  input wire logic [9:0]  char_data,
  input wire logic        self_test_status,
  input wire logic [1:0]  self_test_code,
  input wire logic        recovered_interface_clock_p,
  input wire logic        recovered_interface_clock_n,
  input wire logic        reclocker_clock_out,
  input wire logic [9:0]  rx_parallel_data,
  input wire logic        self_test_status_out,
  input wire logic        reclock_powerdown_flag,
  input wire logic        irq
);
  logic [4:0] m;
  wire  logic ev = char_valid && char_strobe;
  // control register mirror
  always_ff @(posedge clock or posedge rst)
    if (rst) m <= 5'h18;
    else if (wr && addr == 4'h0) m <= wdata[4:0];
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_pd_high: assert property (m[4:3] == 2'h0 |=> reclock_powerdown_flag) else $error("flag low");
  a_pd_low: assert property (m[4:3] != 2'h0 |=> !reclock_powerdown_flag) else $error("flag high");
  a_st_on: assert property (m[2:1] == 2'h2 |=>
    self_test_status_out == $past(self_test_status)) else $error("status not shown");
  a_st_code: assert property (m[2:1] == 2'h2 && ev |=>
    rx_parallel_data[1:0] == $past(self_test_code)) else $error("code not shown");
  a_clk_pair: assert property (recovered_interface_clock_p != recovered_interface_clock_n)
    else $error("clocks not complementary");
  a_full_rate: assert property (!m[0] && ev |=> recovered_interface_clock_p && reclocker_clock_out)
    else $error("full rate edge missing");
  a_half_rate: assert property (m[0] && ev |=>
    recovered_interface_clock_p != $past(recovered_interface_clock_p)) else $error("no toggle");
  a_data_new: assert property (m[2:1] != 2'h2 && ev |=> rx_parallel_data == $past(char_data))
    else $error("data not taken");
  a_reset_state: assert property (disable iff (1'b0) rst && $past(rst) |->
    !reclock_powerdown_flag && !irq && rx_parallel_data == 10'h0) else $error("reset state");
endmodule : rx_clock_props
`default_nettype wire

/* verification/rx_host_model.sv */
// host logic taking parallel characters on interface clock edges
`timescale 1ns/100ps
`default_nettype none
module rx_host_model (
  input  wire logic        clock,
  input  wire logic        half,
  input  wire logic        clk_p,
  input  wire logic [9:0]  data,
  output var  logic [9:0]  last_char,
  output var  logic [15:0] n_chars
);
  logic prev = 1'b0;
  initial n_chars = 16'h0;
  // self-test status pin not taken at all
  always @(posedge clock) begin
    prev <= clk_p;
    if (clk_p !== prev && (half || clk_p)) begin
      last_char <= data;
      n_chars <= n_chars + 16'h1;
    end
  end
endmodule : rx_host_model
`default_nettype wire

/* verification/tb_rx_clock_reclock_status_reset.sv */
// bench for the receive clock block
`timescale 1ns/100ps
`default_nettype none
module tb_rx_clock_reclock_status_reset;
  logic        clock = 0, rst = 1, wr = 0, rd = 0, training_clock = 0, trg_on = 0, half = 0, rk_q = 0;
  logic        char_valid = 0, char_strobe = 0, self_test_status = 0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [9:0]  char_data = 10'h0, rx_parallel_data, last_char;
  logic [1:0]  self_test_code = 2'h0;
  logic        clk_p, clk_n, reclk, st_out, pd, irq;
  logic [15:0] n_chars;
  int          n_errors = 0, total_checks = 0, i, c0, n_rk = 0;
  always #2.5 clock = ~clock;
  always #24 if (trg_on) training_clock = ~training_clock;
  always @(posedge clock) begin
    rk_q <= reclk;
    if (reclk && !rk_q) n_rk++;
  end
  rx_clock_reclock_status_reset rx_clock_reclock_status_reset_i (.clock, .rst, .addr, .wdata, .wr, .rd, .rdata,
    .training_clock, .char_valid, .char_strobe, .char_data, .self_test_status, .self_test_code,
    .recovered_interface_clock_p(clk_p), .recovered_interface_clock_n(clk_n), .reclocker_clock_out(reclk),
    .rx_parallel_data, .self_test_status_out(st_out), .reclock_powerdown_flag(pd), .irq);
  rx_host_model rx_host_model_i (.clock, .half, .clk_p, .data(rx_parallel_data), .last_char, .n_chars);
  task check(string what, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s exp %h seen %h", what, exp, seen);
    end
  endtask : check
  task give_verdict;
    $display("errors %0d checks %0d", n_errors, total_checks);
    if (n_errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  task wreg(logic [3:0] a, logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    repeat (2) @(posedge clock);
  endtask : wreg
  task rreg(logic [3:0] a, logic [31:0] e, string n);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 check(n, rdata, e);
    @(posedge clock);
  endtask : rreg
  task sendc(logic [9:0] d, logic [9:0] mk);
    @(posedge clock);
    char_data <= d;
    char_strobe <= 1'b1;
    @(posedge clock);
    char_strobe <= 1'b0;
    #1 check("data", rx_parallel_data & mk, d & mk);
    repeat (8) @(posedge clock);
  endtask : sendc
  initial begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    rreg(4'h0, 32'h18, "ctrl");
    rreg(4'h4, 32'h0, "status");
    rreg(4'h8, 32'h0, "irq stat");
    rreg(4'h2, 32'h0, "unmapped");
    char_valid <= 1'b1;
    trg_on <= 1'b1;
    for (int r = 0; r < 2; r++) begin
      wreg(4'h0, 32'h18 + r);
      half <= r[0];
      repeat (2) sendc(10'h155, 10'h3FF);
      c0 = n_chars;
      i = n_rk;
      for (int k = 0; k < 4; k++) begin
        sendc(10'h2A5 + k, 10'h3FF);
        check("host char", last_char, 10'h2A5 + k);
      end
      check("chars", n_chars - c0, 4);
      check("reclock", n_rk - i, 4);
    end
    half <= 1'b0;
    wreg(4'h0, 32'h1C);
    self_test_status <= 1'b1;
    self_test_code <= 2'h1;
    sendc(10'h3F0, 10'h3FC);
    check("st code", rx_parallel_data[1:0], 2'h1);
    check("st out", st_out, 1);
    wreg(4'h0, 32'h18);
    check("st off", st_out, 0);
    wreg(4'hC, 32'h1);
    wreg(4'h8, 32'h3);
    wreg(4'h0, 32'h0);
    check("pd", pd, 1);
    check("irq", irq, 1);
    rreg(4'h4, 32'h3, "status");
    wreg(4'h8, 32'h1);
    check("irq clr", irq, 0);
    wreg(4'h0, 32'h8);
    check("pd off", pd, 0);
    check("irq set", irq, 1);
    char_valid <= 1'b0;
    trg_on <= 1'b1;
    c0 = n_chars;
    for (i = 0; i < 400 && n_chars < c0 + 3; i++) @(posedge clock);
    check("training", n_chars >= c0 + 3, 1);
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    rreg(4'h0, 32'h18, "ctrl again");
    give_verdict();
  end
endmodule : tb_rx_clock_reclock_status_reset
bind rx_clock_reclock_status_reset rx_clock_props rx_clock_props_i (.clock, .rst, .addr, .wdata, .wr, .char_valid,
  .char_strobe, .char_data, .self_test_status, .self_test_code, .recovered_interface_clock_p,
  .recovered_interface_clock_n, .reclocker_clock_out, .rx_parallel_data, .self_test_status_out,
  .reclock_powerdown_flag, .irq);
`default_nettype wire
